// file: pdc_pkg.sv
// Function
// - Hardware strap low: duplex from pin
// - Fast poll reports active duplex
// - Software plus autoneg: negotiated duplex wins
// - Software, no autoneg: control bit picks duplex
// - Loopback ignores the duplex control bit
// - Collision test off: collision ignores transmit
// - Collision test on works even in loopback
// - Collision follows transmit within timing limits
// - Control bits six to zero read zero
// - Status at address one, reset defaults
// - Four-pair capability bit always zero
// - Capability bits reset one, override-write only
// - Preamble suppression bit resets zero
// - Autoneg complete latches high, zero when disabled
// - Remote fault latches high on fault
// - Ability and extension bits read one
// - Link status latches low, resets zero
// - Jabber detect latches high on jabber
// - Remote fault clears on status or alias read
// - Override-writable bits need write enable
package pdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Management addresses
    localparam int          MGMT_AW          = 5;
    localparam logic [4:0]  ADDR_CONTROL     = 5'h00;
    localparam logic [4:0]  ADDR_STATUS      = 5'h01;
    localparam logic [4:0]  ADDR_FAST_POLL   = 5'h11;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register field positions
    localparam int          CTL_LOOPBACK     = 14;
    localparam int          CTL_AN_ENABLE    = 12;
    localparam int          CTL_DUPLEX       = 8;
    localparam int          CTL_COL_TEST     = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // Status register layout and reset value
    localparam logic [15:0] STATUS_RESET     = 16'h7809;
    localparam int          ST_CAP_HI        = 14;
    localparam int          ST_CAP_LO        = 11;
    localparam int          ST_RSV_HI        = 10;
    localparam int          ST_RSV_LO        = 7;
    localparam int          ST_PREAMBLE      = 6;
    localparam int          ST_AN_DONE       = 5;
    localparam int          ST_REMOTE_FAULT  = 4;
    localparam int          ST_LINK          = 2;
    localparam int          ST_JABBER        = 1;
    localparam logic        ST_T4_VALUE      = 1'b0;
    localparam logic        ST_AN_ABILITY    = 1'b1;
    localparam logic        ST_EXT_CAP       = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Fast poll register field positions
    localparam int          FP_DUPLEX        = 14;
    localparam int          FP_REMOTE_FAULT  = 1;
    localparam int          FP_LINK          = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Collision test timing
    localparam int          BIT_TIME_PS      = 10000;
    localparam int          CLK_PERIOD_PS    = 100000;
    localparam int          COL_ASSERT_BT    = 512;
    localparam int          COL_DEASSERT_BT  = 4;
    localparam int          COL_ASSERT_RAW   = (COL_ASSERT_BT * BIT_TIME_PS) / CLK_PERIOD_PS;
    localparam int          COL_DEASSERT_RAW = (COL_DEASSERT_BT * BIT_TIME_PS) / CLK_PERIOD_PS;
    localparam int          COL_ASSERT_MAX_CYC   = (COL_ASSERT_RAW < 1) ? 1 : COL_ASSERT_RAW;
    localparam int          COL_DEASSERT_MAX_CYC = (COL_DEASSERT_RAW < 1) ? 1 : COL_DEASSERT_RAW;
    localparam int          COL_ASSERT_DEF_CYC   = 1;
    localparam int          COL_CNT_W        = 6;

endpackage : pdc_pkg

// file: pdc_col_test.sv
`timescale 1ns/10ps
`default_nettype none
module pdc_col_test
    import pdc_pkg::*;
#(
    parameter int ASSERT_CYC = COL_ASSERT_DEF_CYC
) (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic soft_rst_in,
    // Control
    input  wire logic enable_in,
    input  wire logic tx_en_in,
    // Result
    output logic      col_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Delay must fit the counter and the assertion limit
    if (ASSERT_CYC < 1 || ASSERT_CYC > COL_ASSERT_MAX_CYC || ASSERT_CYC >= (1 << COL_CNT_W)) begin : g_chk
        $error("pdc_col_test: ASSERT_CYC out of range");
    end

    localparam logic [COL_CNT_W-1:0] CNT_LAST = COL_CNT_W'(ASSERT_CYC - 1);

    logic [COL_CNT_W-1:0] cnt_q;
    logic [COL_CNT_W-1:0] cnt_d;
    logic                 col_q;
    logic                 col_d;
    logic                 arm;

    // Count while transmit is held; drop at once since release must fit one cycle
    assign arm   = enable_in & tx_en_in;
    assign cnt_d = (!arm) ? '0 : ((cnt_q == CNT_LAST) ? cnt_q : cnt_q + 1'b1);
    assign col_d = arm & (cnt_q == CNT_LAST);

    // Counter and output register
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            col_q <= 1'b0;
        end else if (soft_rst_in) begin
            cnt_q <= '0;
            col_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            col_q <= col_d;
        end
    end

    assign col_out = col_q;

endmodule : pdc_col_test
`default_nettype wire

// file: pdc_regs.sv
`timescale 1ns/10ps
`default_nettype none
module pdc_regs
    import pdc_pkg::*;
#(
    parameter int COL_ASSERT_CYC = COL_ASSERT_DEF_CYC
) (
    // Clock and reset
    input  wire logic               ref_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               soft_rst_in,

    // Management register access
    input  wire logic [MGMT_AW-1:0] mgmt_addr_in,
    input  wire logic               mgmt_wr_in,
    input  wire logic               mgmt_rd_in,
    input  wire logic [15:0]        mgmt_wdata_in,
    output logic [15:0]             mgmt_rdata_out,
    output logic                    mgmt_rvalid_out,

    // Strap and select pins
    input  wire logic               strap_mode_select_in,
    input  wire logic               duplex_select_pin_in,
    input  wire logic               an_select_pin_in,

    // Override-write enable
    input  wire logic               override_writable_en_in,

    // Status events from the link logic
    input  wire logic               an_done_in,
    input  wire logic               an_duplex_full_in,
    input  wire logic               remote_fault_in,
    input  wire logic               link_up_in,
    input  wire logic               jabber_in,

    // MAC side collision path
    input  wire logic               tx_en_in,
    input  wire logic               col_detect_in,
    output logic                    col_out,

    // Resolved operating mode
    output logic                    duplex_full_out,
    output logic                    an_enable_out,
    output logic                    loopback_out,
    output logic                    preamble_suppress_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Latch-high next value: a new event beats a same-cycle clear
    function automatic logic pdc_lh_next(input logic evt, input logic held, input logic clr);
        pdc_lh_next = evt | (held & ~clr);
    endfunction : pdc_lh_next

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int NPIN = 3;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_sync_q;

    assign pin_raw = {an_select_pin_in, duplex_select_pin_in, strap_mode_select_in};

    for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
        // Only the second stage is read by logic
        always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                pin_meta_q[gi] <= 1'b0;
                pin_sync_q[gi] <= 1'b0;
            end else begin
                pin_meta_q[gi] <= pin_raw[gi];
                pin_sync_q[gi] <= pin_meta_q[gi];
            end
        end
    end

    logic sw_mode;
    logic dpx_pin;
    logic an_pin;

    assign sw_mode = pin_sync_q[0];
    assign dpx_pin = pin_sync_q[1];
    assign an_pin  = pin_sync_q[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Access decode
    logic wr_ctl;
    logic wr_st;
    logic rd_st;
    logic rd_fp;
    logic rd_ctl;
    logic rd_hit;

    assign wr_ctl = mgmt_wr_in & (mgmt_addr_in == ADDR_CONTROL);
    assign wr_st  = mgmt_wr_in & (mgmt_addr_in == ADDR_STATUS) & override_writable_en_in;
    assign rd_ctl = mgmt_rd_in & (mgmt_addr_in == ADDR_CONTROL);
    assign rd_st  = mgmt_rd_in & (mgmt_addr_in == ADDR_STATUS);
    assign rd_fp  = mgmt_rd_in & (mgmt_addr_in == ADDR_FAST_POLL);
    assign rd_hit = rd_ctl | rd_st | rd_fp;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register bits
    logic loop_q;
    logic loop_d;
    logic an_en_q;
    logic an_en_d;
    logic dpx_q;
    logic dpx_d;
    logic ctest_q;
    logic ctest_d;

    // Writes are stored even in hardware mode; only the duplex and autoneg bits go unused there
    assign loop_d  = wr_ctl ? mgmt_wdata_in[CTL_LOOPBACK]  : loop_q;
    assign an_en_d = wr_ctl ? mgmt_wdata_in[CTL_AN_ENABLE] : an_en_q;
    assign dpx_d   = wr_ctl ? mgmt_wdata_in[CTL_DUPLEX]    : dpx_q;
    assign ctest_d = wr_ctl ? mgmt_wdata_in[CTL_COL_TEST]  : ctest_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            loop_q  <= 1'b0;
            an_en_q <= 1'b0;
            dpx_q   <= 1'b0;
            ctest_q <= 1'b0;
        end else if (soft_rst_in) begin
            loop_q  <= 1'b0;
            an_en_q <= 1'b0;
            dpx_q   <= 1'b0;
            ctest_q <= 1'b0;
        end else begin
            loop_q  <= loop_d;
            an_en_q <= an_en_d;
            dpx_q   <= dpx_d;
            ctest_q <= ctest_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode resolution
    logic an_active;
    logic duplex_d;
    logic duplex_q;

    // Hardware mode takes autoneg from its pin, software from the bit
    assign an_active = sw_mode ? an_en_q : an_pin;

    // Pin, then negotiated result, then control bit; loopback masks it
    assign duplex_d = (!sw_mode)  ? dpx_pin :
                      an_active   ? an_duplex_full_in :
                      loop_q      ? 1'b0 :
                                    dpx_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            duplex_q <= 1'b0;
        end else if (soft_rst_in) begin
            duplex_q <= 1'b0;
        end else begin
            duplex_q <= duplex_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status register override-writable fields
    localparam logic [3:0] CAP_RESET = STATUS_RESET[ST_CAP_HI:ST_CAP_LO];
    localparam logic [3:0] RSV_RESET = STATUS_RESET[ST_RSV_HI:ST_RSV_LO];
    localparam logic       PRE_RESET = STATUS_RESET[ST_PREAMBLE];

    logic [3:0] cap_q;
    logic [3:0] cap_d;
    logic [3:0] rsv_q;
    logic [3:0] rsv_d;
    logic       pre_q;
    logic       pre_d;

    assign cap_d = wr_st ? mgmt_wdata_in[ST_CAP_HI:ST_CAP_LO] : cap_q;
    assign rsv_d = wr_st ? mgmt_wdata_in[ST_RSV_HI:ST_RSV_LO] : rsv_q;
    assign pre_d = wr_st ? mgmt_wdata_in[ST_PREAMBLE]         : pre_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cap_q <= CAP_RESET;
            rsv_q <= RSV_RESET;
            pre_q <= PRE_RESET;
        end else if (soft_rst_in) begin
            cap_q <= CAP_RESET;
            rsv_q <= RSV_RESET;
            pre_q <= PRE_RESET;
        end else begin
            cap_q <= cap_d;
            rsv_q <= rsv_d;
            pre_q <= pre_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Latching status bits
    logic clr_st;
    logic clr_rf;
    logic clr_link;
    logic an_done_q;
    logic an_done_d;
    logic rf_q;
    logic rf_d;
    logic jab_q;
    logic jab_d;
    logic link_q;
    logic link_d;

    // Fast poll alias shares the fault and link bits
    assign clr_st   = rd_st;
    assign clr_rf   = rd_st | rd_fp;
    assign clr_link = rd_st | rd_fp;

    // Autoneg done is held low while autoneg is off
    assign an_done_d = an_active & pdc_lh_next(an_done_in, an_done_q, clr_st);
    assign rf_d      = pdc_lh_next(remote_fault_in, rf_q, clr_rf);
    assign jab_d     = pdc_lh_next(jabber_in, jab_q, clr_st);

    // Latch low: a drop sticks until read; a read loads the live link state
    assign link_d = link_up_in & (link_q | clr_link);

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            an_done_q <= STATUS_RESET[ST_AN_DONE];
            rf_q      <= STATUS_RESET[ST_REMOTE_FAULT];
            jab_q     <= STATUS_RESET[ST_JABBER];
            link_q    <= STATUS_RESET[ST_LINK];
        end else if (soft_rst_in) begin
            an_done_q <= STATUS_RESET[ST_AN_DONE];
            rf_q      <= STATUS_RESET[ST_REMOTE_FAULT];
            jab_q     <= STATUS_RESET[ST_JABBER];
            link_q    <= STATUS_RESET[ST_LINK];
        end else begin
            an_done_q <= an_done_d;
            rf_q      <= rf_d;
            jab_q     <= jab_d;
            link_q    <= link_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read words; fields not held here read as zero
    logic [15:0] ctl_word;
    logic [15:0] st_word;
    logic [15:0] fp_word;
    logic [15:0] rdata_d;

    always_comb begin
        ctl_word                = '0;
        ctl_word[CTL_LOOPBACK]  = loop_q;
        ctl_word[CTL_AN_ENABLE] = an_en_q;
        ctl_word[CTL_DUPLEX]    = dpx_q;
        ctl_word[CTL_COL_TEST]  = ctest_q;
    end

    // Fixed bits are constants, so no write disturbs them
    assign st_word = {ST_T4_VALUE,
                      cap_q,
                      rsv_q,
                      pre_q,
                      an_done_q,
                      rf_q,
                      ST_AN_ABILITY,
                      link_q,
                      jab_q,
                      ST_EXT_CAP};

    always_comb begin
        fp_word                  = '0;
        fp_word[FP_DUPLEX]       = duplex_q;
        fp_word[FP_REMOTE_FAULT] = rf_q;
        fp_word[FP_LINK]         = link_q;
    end

    // Unmapped addresses answer zero
    assign rdata_d = rd_ctl ? ctl_word :
                     rd_st  ? st_word  :
                     rd_fp  ? fp_word  :
                              16'h0000;

    logic [15:0] rdata_q;
    logic        rvalid_q;

    // Read data register; the word shows pre-clear latch values
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= (mgmt_rd_in) ? rdata_d : rdata_q;
            rvalid_q <= mgmt_rd_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Collision path
    logic test_col;
    logic col_d;
    logic col_q;

    pdc_col_test #(
        .ASSERT_CYC (COL_ASSERT_CYC)
    ) u_col_test (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .soft_rst_in (soft_rst_in),
        .enable_in   (ctest_q),
        .tx_en_in    (tx_en_in),
        .col_out     (test_col)
    );

    // Test overrides loopback masking; plain loopback silences the detector
    assign col_d = ctest_q ? test_col :
                   loop_q  ? 1'b0     :
                             col_detect_in;

    // Direct collision path flop
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            col_q <= 1'b0;
        end else begin
            col_q <= ctest_q ? 1'b0 : col_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode outputs
    logic an_out_q;
    logic pre_out_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            an_out_q  <= 1'b0;
            pre_out_q <= 1'b0;
        end else begin
            an_out_q  <= an_active;
            pre_out_q <= pre_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output drive
    assign mgmt_rdata_out        = rdata_q;
    assign mgmt_rvalid_out       = rvalid_q;
    assign duplex_full_out       = duplex_q;
    assign an_enable_out         = an_out_q;
    assign loopback_out          = loop_q;
    assign preamble_suppress_out = pre_out_q;
    assign col_out               = ctest_q ? test_col : col_q;  // Both terms are flops

endmodule : pdc_regs
`default_nettype wire

// file: pdc_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pdc_regs_asserts
    import pdc_pkg::*;
(
    // Clock and reset
    input wire logic               ref_clk_in,
    input wire logic               rst_n_in,
    input wire logic               soft_rst_in,
    // Management access
    input wire logic [MGMT_AW-1:0] mgmt_addr_in,
    input wire logic               mgmt_wr_in,
    input wire logic               mgmt_rd_in,
    input wire logic [15:0]        mgmt_wdata_in,
    input wire logic [15:0]        mgmt_rdata_out,
    input wire logic               mgmt_rvalid_out,
    // Status events and collision path
    input wire logic               link_up_in,
    input wire logic               remote_fault_in,
    input wire logic               an_enable_out,
    input wire logic               tx_en_in,
    input wire logic               col_detect_in,
    input wire logic               col_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Reads that clear the latched bits
    wire st_rd  = mgmt_rd_in && (mgmt_addr_in == ADDR_STATUS);
    wire clr_rd = st_rd || (mgmt_rd_in && (mgmt_addr_in == ADDR_FAST_POLL));
    logic ct_q;
    // Shadow of the collision test bit
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ct_q <= 1'b0;
        else if (soft_rst_in)
            ct_q <= 1'b0;
        else if (mgmt_wr_in && (mgmt_addr_in == ADDR_CONTROL))
            ct_q <= mgmt_wdata_in[CTL_COL_TEST];
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_rvalid; mgmt_rd_in |=> mgmt_rvalid_out; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read without valid");
    property p_fixed; st_rd |=> !mgmt_rdata_out[15] && mgmt_rdata_out[3] && mgmt_rdata_out[0];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");
    property p_rsv; mgmt_rd_in && (mgmt_addr_in == ADDR_CONTROL) |=> mgmt_rdata_out[6:0] == 7'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("control low bits not zero");
    property p_col_on; ct_q && tx_en_in && !soft_rst_in |=> col_out; endproperty
    a_col_on: assert property (p_col_on) else $error("collision late");
    property p_col_off; ct_q && !tx_en_in && !soft_rst_in |=> !col_out; endproperty
    a_col_off: assert property (p_col_off) else $error("collision held");
    property p_col_quiet; !ct_q && !col_detect_in |=> !col_out; endproperty
    a_col_quiet: assert property (p_col_quiet) else $error("collision follows tx");
    property p_link; !link_up_in ##1 !clr_rd ##1 st_rd |=> !mgmt_rdata_out[ST_LINK]; endproperty
    a_link: assert property (p_link) else $error("link drop lost");
    property p_fault;
        remote_fault_in && !soft_rst_in ##1 !clr_rd && !soft_rst_in ##1 st_rd && !soft_rst_in
            |=> mgmt_rdata_out[ST_REMOTE_FAULT];
    endproperty
    a_fault: assert property (p_fault) else $error("remote fault not latched");
    property p_an_off; !an_enable_out ##1 !an_enable_out && st_rd |=> !mgmt_rdata_out[ST_AN_DONE];
    endproperty
    a_an_off: assert property (p_an_off) else $error("an done while disabled");
endmodule : pdc_regs_asserts
bind pdc_regs pdc_regs_asserts chk_u (.*);
`default_nettype wire

// file: pdc_sta_model.sv
`timescale 1ns/10ps
`default_nettype none
module pdc_sta_model
    import pdc_pkg::*;
(
    // Clock
    input wire logic               ref_clk_in,
    // Requests
    output var logic [MGMT_AW-1:0] mgmt_addr_out,
    output var logic               mgmt_wr_out,
    output var logic               mgmt_rd_out,
    output var logic [15:0]        mgmt_wdata_out,
    // Answers
    input wire logic [15:0]        mgmt_rdata_in,
    input wire logic               mgmt_rvalid_in
);
    // Idle bus at time zero
    initial begin
        mgmt_addr_out  = 5'h1F;
        mgmt_wr_out    = 1'b0;
        mgmt_rd_out    = 1'b0;
        mgmt_wdata_out = 16'h0000;
    end
    // Released lines flip so stale values never look current
    task automatic release_bus();
        mgmt_wr_out    = 1'b0;
        mgmt_rd_out    = 1'b0;
        mgmt_addr_out  = ~mgmt_addr_out;
        mgmt_wdata_out = ~mgmt_wdata_out;
    endtask : release_bus
    // Reserved bits go out at their defaults
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        @(negedge ref_clk_in);
        mgmt_addr_out  = a;
        mgmt_wr_out    = 1'b1;
        mgmt_wdata_out = (a == ADDR_STATUS) ? ((d & 16'h7840) | 16'h0009) : (d & 16'h5180);
        @(negedge ref_clk_in);
        release_bus();
    endtask : write_reg
    // One strobe, then a bounded wait for the valid pulse
    task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
        int n;
        n = 0;
        @(negedge ref_clk_in);
        mgmt_addr_out = a;
        mgmt_rd_out   = 1'b1;
        @(negedge ref_clk_in);
        release_bus();
        while (mgmt_rvalid_in !== 1'b1 && n < 4) begin
            @(negedge ref_clk_in);
            n++;
        end
        d = (mgmt_rvalid_in === 1'b1) ? mgmt_rdata_in : 16'hXXXX;
    endtask : read_reg
endmodule : pdc_sta_model
`default_nettype wire

// file: test_phy_duplex_collision_status_regs.sv
`timescale 1ns/10ps
`default_nettype none
module test_phy_duplex_collision_status_regs
    import pdc_pkg::*;
;
    logic clk, rst_n, srst, wr, rd, rvalid, strap, dpx_pin, an_pin, ovr, an_done, an_dup;
    logic rfault, link, jab, tx_en, col_det, col, dup_o, ane_o, lb_o, pre_o, e;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, st_m, v;
    int          err_count = 0, n_compared = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    pdc_regs dut_u (
        .ref_clk_in(clk), .rst_n_in(rst_n), .soft_rst_in(srst), .mgmt_addr_in(addr),
        .mgmt_wr_in(wr), .mgmt_rd_in(rd), .mgmt_wdata_in(wdata), .mgmt_rdata_out(rdata),
        .mgmt_rvalid_out(rvalid), .strap_mode_select_in(strap), .duplex_select_pin_in(dpx_pin),
        .an_select_pin_in(an_pin), .override_writable_en_in(ovr), .an_done_in(an_done),
        .an_duplex_full_in(an_dup), .remote_fault_in(rfault), .link_up_in(link),
        .jabber_in(jab), .tx_en_in(tx_en), .col_detect_in(col_det), .col_out(col),
        .duplex_full_out(dup_o), .an_enable_out(ane_o), .loopback_out(lb_o),
        .preamble_suppress_out(pre_o));
    pdc_sta_model sta_u (
        .ref_clk_in(clk), .mgmt_addr_out(addr), .mgmt_wr_out(wr), .mgmt_rd_out(rd),
        .mgmt_wdata_out(wdata), .mgmt_rdata_in(rdata), .mgmt_rvalid_in(rvalid));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic chk1(input string what, input logic seen, input logic exp);
        check(what, {15'h0000, seen}, {15'h0000, exp});
    endtask : chk1
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        sta_u.read_reg(a, d);
        check(what, d, exp);
    endtask : rd_chk
    // Status read: latches clear, link takes live state
    task automatic rd_st();
        rd_chk(ADDR_STATUS, st_m, "status");
        st_m = (st_m & 16'hFFC9) | {13'h0, link, 2'h0};
    endtask : rd_st
    task automatic rd_fp(input logic dup);
        rd_chk(ADDR_FAST_POLL, {1'b0, dup, 12'h000, st_m[4], st_m[2]}, "fast poll");
        st_m = (st_m & 16'hFFEB) | {13'h0, link, 2'h0};
    endtask : rd_fp
    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_n, srst, strap, dpx_pin, an_pin, ovr, an_done, an_dup} = 8'h00;
        {rfault, link, jab, tx_en, col_det} = 5'h00;
        strap = 1'b1;
        st_m = 16'h7809;
        void'($urandom(20991));
        repeat (8) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        rd_st();
        rd_chk(ADDR_CONTROL, 16'h0000, "control");
        rd_chk(5'h05, 16'h0000, "unmapped");
        $display("test reset done");
        v = 16'($urandom) & 16'h7840;
        sta_u.write_reg(ADDR_STATUS, v ^ 16'h7840);
        rd_st();
        ovr = 1'b1;
        sta_u.write_reg(ADDR_STATUS, v);
        st_m = (st_m & 16'h87BF) | v;
        rd_st();
        chk1("preamble", pre_o, v[6]);
        sta_u.write_reg(ADDR_STATUS, 16'h7800);
        ovr = 1'b0;
        st_m = (st_m & 16'h87BF) | 16'h7800;
        $display("test override done");
        @(negedge clk) {rfault, jab} = 2'b11;
        @(negedge clk) {rfault, jab} = 2'b00;
        st_m = st_m | 16'h0012;
        rd_st();
        rd_st();
        @(negedge clk) rfault = 1'b1;
        @(negedge clk) rfault = 1'b0;
        st_m = st_m | 16'h0010;
        rd_fp(1'b0);
        rd_st();
        link = 1'b1;
        rd_st();
        rd_st();
        @(negedge clk) link = 1'b0;
        @(negedge clk) link = 1'b1;
        st_m = st_m & 16'hFFFB;
        rd_st();
        rd_st();
        sta_u.write_reg(ADDR_CONTROL, 16'h1000);
        @(negedge clk) an_done = 1'b1;
        @(negedge clk) an_done = 1'b0;
        st_m = st_m | 16'h0020;
        rd_st();
        sta_u.write_reg(ADDR_CONTROL, 16'h0000);
        repeat (2) @(negedge clk);
        @(negedge clk) an_done = 1'b1;
        @(negedge clk) an_done = 1'b0;
        rd_st();
        $display("test latch done");
        // All strap, duplex pin, enable, duplex and loopback cases
        for (int i = 0; i < 32; i++) begin
            {strap, dpx_pin} = {i[0], i[1]};
            {an_pin, an_dup} = 2'($urandom);
            sta_u.write_reg(ADDR_CONTROL, {1'b0, i[4], 1'b0, i[2], 3'h0, i[3], 8'h00});
            repeat (5) @(negedge clk);
            e = !strap ? dpx_pin : (i[2] ? an_dup : (i[4] ? 1'b0 : i[3]));
            chk1("duplex", dup_o, e);
            chk1("an enable", ane_o, strap ? i[2] : an_pin);
            chk1("loopback", lb_o, i[4]);
            rd_fp(e);
        end
        $display("test duplex done");
        sta_u.write_reg(ADDR_CONTROL, 16'h4080);
        @(negedge clk) tx_en = 1'b1;
        @(negedge clk) chk1("col rise", col, 1'b1);
        repeat (3) @(negedge clk);
        chk1("col hold", col, 1'b1);
        tx_en = 1'b0;
        @(negedge clk) chk1("col fall", col, 1'b0);
        sta_u.write_reg(ADDR_CONTROL, 16'h0000);
        @(negedge clk) tx_en = 1'b1;
        repeat (2) @(negedge clk);
        chk1("col idle", col, 1'b0);
        col_det = 1'b1;
        @(negedge clk) chk1("col normal", col, 1'b1);
        {tx_en, col_det} = 2'b00;
        $display("test collision done");
        @(negedge clk) srst = 1'b1;
        @(negedge clk) srst = 1'b0;
        st_m = 16'h7809;
        rd_st();
        $display("test soft reset done");
        summarize();
    end
endmodule : test_phy_duplex_collision_status_regs
`default_nettype wire
